// ---- core/lbbp_top.sv ----
// LED blink, breathe and general-purpose PWM generator with watchdog.
// Overview of operation
// R01: Blinking: free 8-bit counter, duty used unchanged.
// R02: Blinking: counter steps on delay terminal counts.
// R03: Duty zero off, all ones on, proportional.
// R04: Blink and PWM ignore resolution, stay 8-bit.
// R05: Prescale from delay reload, duty from lower limit.
// R06: Frequency is clock over prescale+1 over period.
// R07: General-purpose PWM has 8-bit watchdog with reload.
// R08: Watchdog loads 0x14 at reset, reloads on writes.
// R09: Watchdog decrements per 5 Hz tick while non-zero.
// R10: Watchdog expiry raises interrupt, forces mode 3.
// R11: Timeout interrupt is a one-cycle pulse.
// R12: Stopped ticks hold watchdog count; resume continues.
// R13: Zero reload disables watchdog; unit is 200 ms.
// R14: Breathing period counter wraps at 256, 128, 64.
// R15: Output on while period counter below duty.
// R16: Off mode or reset bit clears all counters except the watchdog.
// R17: Ramp up by step to upper limit, hold.
// R18: Ramp down to lower limit, hold, repeat.
// R19: Symmetric ramps use all eight segment fields.
// R20: Asymmetric ramps split segments four and four.
// R21: Symmetric segment index is duty bits 7:5.
// R22: Asymmetric index is falling flag plus duty 7:6.
// R23: Breathing always uses the slow clock ticks.
// R24: Mode 0 off, 1 breathe, 2 blink/PWM, 3 on.
// R25: Delay counter reloads; zero prescale passes through.
`timescale 1ns/1ns
module lbbp_top
	import lbbp_pkg::*;
#(
	parameter int PRESCALE_W = 12,
	parameter int HOLD_W     = 12
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire logic                  slow_clock_tick,
	input  wire logic                  fast_clock_tick,
	input  wire logic                  wdog_tick,
	input  wire logic                  cfg_wr,
	input  wire logic [1:0]            cfg_output_mode,
	input  wire logic                  cfg_clock_source,
	input  wire logic                  cfg_symmetric,
	input  wire logic [1:0]            cfg_counter_resolution,
	input  wire logic [7:0]            cfg_watchdog_reload,
	input  wire logic                  cfg_soft_reset,
	input  wire logic                  lim_min_wr,
	input  wire logic                  lim_max_wr,
	input  wire logic [7:0]            lim_min,
	input  wire logic [7:0]            lim_max,
	input  wire logic [PRESCALE_W-1:0] prescale_reload,
	input  wire logic [HOLD_W-1:0]     hold_time,
	input  wire logic [31:0]           segment_step_sizes,
	input  wire logic [31:0]           segment_update_intervals,
	output logic                       pwm_out,
	output logic                       watchdog_timeout_irq,
	output logic [1:0]                 output_mode,
	output logic [7:0]                 duty_status,
	output logic [7:0]                 watchdog_count
);

	// Configuration and limit registers written by software.
	logic                  clock_source;
	logic                  symmetric;
	logic [1:0]            counter_resolution;
	logic [7:0]            watchdog_reload;
	logic                  soft_reset;
	logic [7:0]            lower_limit;
	logic [7:0]            upper_limit;

	// Working state.
	logic [7:0]            period_counter;
	logic [7:0]            duty;
	logic [LBBP_SEG_W-1:0] interval_count;
	logic [HOLD_W-1:0]     hold_count;
	lbbp_state_e           state;
	lbbp_state_e           next_state;
	logic [7:0]            next_duty;

	// Decoded controls and internal strobes.
	logic                  breathe_mode;
	logic                  blink_mode;
	logic                  clear_all;
	logic                  src_tick;
	logic                  period_wrap;
	logic                  delay_tick;
	logic                  delay_term;
	logic                  wdog_expire;
	logic                  wdog_reload_req;
	logic [7:0]            wdog_reload_val;
	logic [7:0]            wrap_value;
	logic [2:0]            seg_index;
	logic [LBBP_SEG_W-1:0] seg_step;
	logic [LBBP_SEG_W-1:0] seg_interval;
	logic [8:0]            duty_up;
	logic [8:0]            duty_down;
	logic                  step_now;
	logic                  pwm_level;

	// Mode decode; off mode and the reset bit both clear the engine.
	assign breathe_mode = (output_mode == LBBP_MODE_BREATHE); // [R24]
	assign blink_mode   = (output_mode == LBBP_MODE_BLINK);   // [R24]
	assign clear_all    = (output_mode == LBBP_MODE_OFF) || soft_reset; // [R16]

	// Blinking picks the slow or fast tick; breathing is slow only.
	assign src_tick = breathe_mode ? slow_clock_tick :          // [R23]
		((clock_source == LBBP_SRC_FAST) ? fast_clock_tick :
		slow_clock_tick);

	// Wrap point of the period counter; blink mode is always 8-bit.
	always_comb begin
		if (!breathe_mode) begin
			wrap_value = LBBP_WRAP_8BIT;                          // [R04]
		end else begin
			case (counter_resolution)                            // [R14]
				LBBP_RES_7BIT: wrap_value = LBBP_WRAP_7BIT;
				LBBP_RES_6BIT: wrap_value = LBBP_WRAP_6BIT;
				default:       wrap_value = LBBP_WRAP_8BIT;
			endcase
		end
	end

	// Breathing clocks the delay counter from each period wrap; blinking
	// feeds it the source tick so it prescales the period counter.
	assign period_wrap = breathe_mode && slow_clock_tick &&
		(period_counter == wrap_value);
	assign delay_tick  = breathe_mode ? period_wrap : src_tick;

	// Prescale comes from the delay reload field in every mode.
	lbbp_divider #(
		.WIDTH (PRESCALE_W)
	) u_delay (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (clear_all),
		.tick     (delay_tick),
		.reload   (prescale_reload),   // [R05] [R06]
		.term     (delay_term)
	);

	// Watchdog reloads whenever the configuration or lower limit is written.
	assign wdog_reload_req = cfg_wr || lim_min_wr;               // [R08]
	// A configuration write brings its own reload value; a duty write
	// reuses the stored field, so a stale input port cannot leak in.
	assign wdog_reload_val = cfg_wr ? cfg_watchdog_reload :
		watchdog_reload;                                         // [R08]

	lbbp_wdog u_wdog (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.reload_req (wdog_reload_req),
		.reload_val (wdog_reload_val), // [R07]
		.wdog_tick  (wdog_tick),
		.count      (watchdog_count),
		.expire     (wdog_expire)
	);

	// Configuration register; a watchdog expiry forces the output mode to
	// fully on and wins over a simultaneous write, other fields untouched.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			output_mode        <= LBBP_MODE_RST;
			clock_source       <= LBBP_SRC_SLOW;
			symmetric          <= 1'b0;
			counter_resolution <= LBBP_RES_8BIT;
			watchdog_reload    <= LBBP_WDOG_RELOAD_RST;
			soft_reset         <= 1'b0;
		end else begin
			if (cfg_wr) begin
				output_mode        <= cfg_output_mode;
				clock_source       <= cfg_clock_source;
				symmetric          <= cfg_symmetric;
				counter_resolution <= cfg_counter_resolution;
				watchdog_reload    <= cfg_watchdog_reload;
				soft_reset         <= cfg_soft_reset;
			end
			if (wdog_expire) begin
				output_mode <= LBBP_MODE_ON;                       // [R10]
			end
		end
	end

	// Limit registers.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lower_limit <= 8'h00;
			upper_limit <= 8'h00;
		end else begin
			if (lim_min_wr) begin
				lower_limit <= lim_min;
			end
			if (lim_max_wr) begin
				upper_limit <= lim_max;
			end
		end
	end

	// One-cycle interrupt pulse per watchdog timeout.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_timeout_irq <= 1'b0;
		end else begin
			watchdog_timeout_irq <= wdog_expire;                  // [R10] [R11]
		end
	end

	// Period counter: breathing counts slow ticks and wraps at the
	// resolution; blinking counts delay terminal counts, free running.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			period_counter <= 8'h00;
		end else if (clear_all) begin
			period_counter <= 8'h00;                              // [R16]
		end else if (breathe_mode && slow_clock_tick) begin
			if (period_counter >= wrap_value) begin
				period_counter <= 8'h00;                          // [R14]
			end else begin
				period_counter <= period_counter + 8'h01;
			end
		end else if (blink_mode && delay_term) begin
			period_counter <= period_counter + 8'h01;             // [R01] [R02]
		end
	end

	// Segment selection from the duty value and ramp direction.
	always_comb begin
		if (symmetric) begin
			seg_index = duty[7:5];                                // [R19] [R21]
		end else begin
			seg_index = {state == LBBP_ST_FALL, duty[7:6]};       // [R20] [R22]
		end
	end

	assign seg_step     = segment_step_sizes[seg_index*LBBP_SEG_W +:
		LBBP_SEG_W];
	assign seg_interval = segment_update_intervals[seg_index*LBBP_SEG_W +:
		LBBP_SEG_W];
	assign duty_up      = {1'b0, duty} + {5'h00, seg_step};
	assign duty_down    = {1'b0, duty} - {5'h00, seg_step};

	// A ramp step is taken once the segment interval of delay terminal
	// counts has elapsed.
	assign step_now = delay_term && (interval_count >= seg_interval);

	// Interval counter between ramp steps.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			interval_count <= '0;
		end else if (clear_all || !breathe_mode) begin
			interval_count <= '0;                                 // [R16]
		end else if (delay_term) begin
			if (step_now) begin
				interval_count <= '0;
			end else begin
				interval_count <= interval_count + 1'b1;
			end
		end
	end

	// Breathing sequencer next state and next duty.
	always_comb begin
		next_state = state;
		next_duty  = duty;
		case (state)
			LBBP_ST_RISE: begin
				if (duty >= upper_limit) begin
					next_state = LBBP_ST_HOLD_HI;
				end else if (step_now) begin
					if (duty_up[8] || duty_up[7:0] >= upper_limit) begin
						next_duty  = upper_limit;                     // [R17]
						next_state = LBBP_ST_HOLD_HI;
					end else begin
						next_duty = duty_up[7:0];                     // [R17]
					end
				end
			end
			LBBP_ST_HOLD_HI: begin
				if (delay_term && hold_count >= hold_time) begin
					next_state = LBBP_ST_FALL;                        // [R17]
				end
			end
			LBBP_ST_FALL: begin
				if (duty <= lower_limit) begin
					next_state = LBBP_ST_HOLD_LO;
				end else if (step_now) begin
					if (duty_down[8] || duty_down[7:0] <= lower_limit) begin
						next_duty  = lower_limit;                     // [R18]
						next_state = LBBP_ST_HOLD_LO;
					end else begin
						next_duty = duty_down[7:0];                   // [R18]
					end
				end
			end
			LBBP_ST_HOLD_LO: begin
				if (delay_term && hold_count >= hold_time) begin
					next_state = LBBP_ST_RISE;                        // [R18]
				end
			end
			default: begin
				next_state = LBBP_ST_RISE;
				next_duty  = 8'h00;
			end
		endcase
	end

	// Sequencer state and duty register; both clear when the engine is off.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= LBBP_ST_RISE;
			duty  <= 8'h00;
		end else if (clear_all || !breathe_mode) begin
			state <= LBBP_ST_RISE;                                // [R16]
			duty  <= 8'h00;
		end else begin
			state <= next_state;
			duty  <= next_duty;
		end
	end

	// Hold counter counts delay terminal counts while holding at a limit.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_count <= '0;
		end else if (clear_all || !breathe_mode || next_state != state) begin
			hold_count <= '0;                                     // [R16]
		end else if (delay_term && (state == LBBP_ST_HOLD_HI ||
				state == LBBP_ST_HOLD_LO)) begin
			hold_count <= hold_count + 1'b1;
		end
	end

	// Output level by mode; blink duty is the lower limit as written.
	always_comb begin
		case (output_mode)
			LBBP_MODE_OFF:     pwm_level = 1'b0;                 // [R24]
			LBBP_MODE_ON:      pwm_level = 1'b1;                 // [R24]
			LBBP_MODE_BREATHE: pwm_level = period_counter < duty; // [R15]
			LBBP_MODE_BLINK: begin
				pwm_level = (lower_limit == LBBP_DUTY_FULL) ||     // [R03]
					(period_counter < lower_limit);                // [R01] [R05]
			end
			default:           pwm_level = 1'b0;
		endcase
	end

	// Registered pin output and duty status.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_out     <= 1'b0;
			duty_status <= 8'h00;
		end else begin
			pwm_out     <= pwm_level;                             // [R03] [R15]
			duty_status <= blink_mode ? lower_limit : duty;
		end
	end

endmodule : lbbp_top

// ---- core/lbbp_pkg.sv ----
// Shared constants and types for the LED blink and breathe PWM block.
package lbbp_pkg;

	// Output-mode field codes.
	localparam logic [1:0] LBBP_MODE_OFF     = 2'h0;
	localparam logic [1:0] LBBP_MODE_BREATHE = 2'h1;
	localparam logic [1:0] LBBP_MODE_BLINK   = 2'h2;
	localparam logic [1:0] LBBP_MODE_ON      = 2'h3;

	// Clock-source select codes for blinking and general-purpose operation.
	localparam logic LBBP_SRC_SLOW = 1'b0;
	localparam logic LBBP_SRC_FAST = 1'b1;

	// Counter-resolution codes and the matching wrap values.
	localparam logic [1:0] LBBP_RES_8BIT = 2'h0;
	localparam logic [1:0] LBBP_RES_7BIT = 2'h1;
	localparam logic [1:0] LBBP_RES_6BIT = 2'h2;
	localparam logic [7:0] LBBP_WRAP_8BIT = 8'hFF;
	localparam logic [7:0] LBBP_WRAP_7BIT = 8'h7F;
	localparam logic [7:0] LBBP_WRAP_6BIT = 8'h3F;

	// Duty value that holds the output fully active.
	localparam logic [7:0] LBBP_DUTY_FULL = 8'hFF;

	// Values after reset.
	localparam logic [7:0] LBBP_WDOG_RELOAD_RST = 8'h14;
	localparam logic [1:0] LBBP_MODE_RST        = 2'h0;

	// Width of one segment field in the step and interval words.
	localparam int LBBP_SEG_W = 4;

	// Breathing sequencer states, one-hot.
	typedef enum logic [3:0] {
		LBBP_ST_RISE    = 4'b0001,
		LBBP_ST_HOLD_HI = 4'b0010,
		LBBP_ST_FALL    = 4'b0100,
		LBBP_ST_HOLD_LO = 4'b1000
	} lbbp_state_e;

endpackage : lbbp_pkg

// ---- core/lbbp_divider.sv ----
// Reloading down counter that acts as the delay prescaler.
`timescale 1ns/1ns
module lbbp_divider
	import lbbp_pkg::*;
#(
	parameter int WIDTH = 12
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] reload,
	output logic                  term
);

	logic [WIDTH-1:0] count;

	// Count input ticks down and reload at the terminal count; a zero reload
	// makes every tick terminal so the input passes straight through.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			term  <= 1'b0;
		end else if (clear) begin
			count <= '0;
			term  <= 1'b0;
		end else if (tick) begin
			if (count == '0) begin
				count <= reload; // [R25]
				term  <= 1'b1;   // [R02]
			end else begin
				count <= count - 1'b1;
				term  <= 1'b0;
			end
		end else begin
			term <= 1'b0;
		end
	end

endmodule : lbbp_divider

// ---- core/lbbp_wdog.sv ----
// Watchdog down counter for general-purpose PWM use.
`timescale 1ns/1ns
module lbbp_wdog
	import lbbp_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       reload_req,
	input  wire logic [7:0] reload_val,
	input  wire logic       wdog_tick,
	output logic [7:0]      count,
	output logic            expire
);

	// Load the reset reload at reset, reload on software writes, and step
	// down once per 5 Hz tick while non-zero; without ticks the value holds.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count  <= LBBP_WDOG_RELOAD_RST; // [R08]
			expire <= 1'b0;
		end else if (reload_req) begin
			count  <= reload_val;           // [R08] [R13]
			expire <= 1'b0;
		end else if (wdog_tick && count != 8'h00) begin
			count  <= count - 8'h01;        // [R09] [R12]
			expire <= (count == 8'h01);     // [R10]
		end else begin
			expire <= 1'b0;
		end
	end

endmodule : lbbp_wdog

// ---- tb/lbbp_led_model.sv ----
// Far-side model of the LED pin that integrates its lit time.
`timescale 1ns/1ns
module lbbp_led_model
(
	input  wire logic   core_clk,
	input  wire logic   pin,
	input  wire logic   clr,
	output logic [15:0] high_cnt
);
	// Counts lit cycles since the last clear; an unknown pin never counts.
	always_ff @(posedge core_clk) begin
		if (clr)
			high_cnt <= 16'h0000;
		else if (pin === 1'b1)
			high_cnt <= high_cnt + 16'h0001;
	end
endmodule : lbbp_led_model

// ---- tb/lbbp_chk.sv ----
// Port-level checker for the LED blink and breathe PWM block.
`timescale 1ns/1ns
module lbbp_chk
	import lbbp_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       wdog_tick,
	input wire logic       cfg_wr,
	input wire logic [1:0] cfg_output_mode,
	input wire logic [7:0] cfg_watchdog_reload,
	input wire logic       lim_min_wr,
	input wire logic       pwm_out,
	input wire logic       watchdog_timeout_irq,
	input wire logic [1:0] output_mode,
	input wire logic [7:0] duty_status,
	input wire logic [7:0] watchdog_count
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// No write that reloads the watchdog is pending this cycle.
	logic no_wr;
	assign no_wr = !cfg_wr && !lim_min_wr;

	property p_wd_load;
		cfg_wr |=> watchdog_count == $past(cfg_watchdog_reload);
	endproperty
	a_wd_load: assert property (p_wd_load) else $error("wdog load");
	property p_wd_dec;
		wdog_tick && no_wr && watchdog_count != 8'h00
			|=> watchdog_count == $past(watchdog_count) - 8'h01;
	endproperty
	a_wd_dec: assert property (p_wd_dec) else $error("wdog step");
	property p_wd_hold;
		!wdog_tick && no_wr |=> $stable(watchdog_count);
	endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("wdog hold");
	property p_wd_zero;
		watchdog_count == 8'h00 && no_wr |=> watchdog_count == 8'h00;
	endproperty
	a_wd_zero: assert property (p_wd_zero) else $error("wdog zero");
	property p_expire;
		wdog_tick && no_wr && watchdog_count == 8'h01
			|-> ##2 (watchdog_timeout_irq && output_mode == LBBP_MODE_ON);
	endproperty
	a_expire: assert property (p_expire) else $error("no expiry");
	property p_pulse;
		watchdog_timeout_irq |=> !watchdog_timeout_irq;
	endproperty
	a_pulse: assert property (p_pulse) else $error("irq width");
	property p_irq_cause;
		$rose(watchdog_timeout_irq) |-> $past(watchdog_count) == 8'h00
			&& $past(watchdog_count, 2) == 8'h01;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
	property p_mode_wr;
		cfg_wr && watchdog_count != 8'h00
			|=> output_mode == $past(cfg_output_mode);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode write");
	// Duty status trails the engine clear by two cycles.
	property p_off;
		(output_mode == LBBP_MODE_OFF) [*3] |-> !pwm_out && duty_status == 8'h00;
	endproperty
	a_off: assert property (p_off) else $error("off mode");
	property p_on;
		(output_mode == LBBP_MODE_ON) [*2] |-> pwm_out;
	endproperty
	a_on: assert property (p_on) else $error("on mode");
	property p_full;
		(output_mode == LBBP_MODE_BLINK && duty_status == LBBP_DUTY_FULL) [*3]
			|-> pwm_out;
	endproperty
	a_full: assert property (p_full) else $error("duty full");

	c_expire: cover property (watchdog_timeout_irq);
	c_blink: cover property (output_mode == LBBP_MODE_BLINK && pwm_out);
	c_breathe: cover property (output_mode == LBBP_MODE_BREATHE && pwm_out);
endmodule : lbbp_chk

bind lbbp_top lbbp_chk i_chk (.core_clk, .rst_n, .wdog_tick, .cfg_wr,
	.cfg_output_mode, .cfg_watchdog_reload, .lim_min_wr, .pwm_out,
	.watchdog_timeout_irq, .output_mode, .duty_status, .watchdog_count);

// ---- tb/test_led_blink_breathe_pwm.sv ----
// Testbench of the LED blink and breathe PWM block.
`timescale 1ns/1ns
module test_led_blink_breathe_pwm
	import lbbp_pkg::*;
;
	logic        core_clk = 1'b0, rst_n = 1'b0;
	logic        slow_clock_tick = 1'b0, fast_clock_tick = 1'b0;
	logic        wdog_tick = 1'b0, cfg_wr = 1'b0, cfg_clock_source = 1'b0;
	logic        cfg_symmetric = 1'b1, cfg_soft_reset = 1'b0;
	logic        lim_min_wr = 1'b0, lim_max_wr = 1'b0;
	logic [1:0]  cfg_output_mode = 2'h0, cfg_counter_resolution = 2'h0;
	logic [7:0]  cfg_watchdog_reload = 8'h00, lim_min = 8'h00, lim_max = 8'h00;
	logic [11:0] prescale_reload = 12'h000, hold_time = 12'h004;
	logic [31:0] segment_step_sizes = 32'hFFFFFFFF;
	logic [31:0] segment_update_intervals = 32'h00000000;
	logic        pwm_out, watchdog_timeout_irq;
	logic [1:0]  output_mode;
	logic [7:0]  duty_status, watchdog_count;
	logic        slow_en = 1'b0, fast_en = 1'b0, mon_clr = 1'b1;
	logic [15:0] high_cnt;
	int          error_cnt = 0, checked = 0, irq_cnt = 0;

	lbbp_top i_dut (.core_clk, .rst_n, .slow_clock_tick, .fast_clock_tick,
		.wdog_tick, .cfg_wr, .cfg_output_mode, .cfg_clock_source,
		.cfg_symmetric, .cfg_counter_resolution, .cfg_watchdog_reload,
		.cfg_soft_reset, .lim_min_wr, .lim_max_wr, .lim_min, .lim_max,
		.prescale_reload, .hold_time, .segment_step_sizes,
		.segment_update_intervals, .pwm_out, .watchdog_timeout_irq,
		.output_mode, .duty_status, .watchdog_count);
	lbbp_led_model i_led (.core_clk, .pin(pwm_out), .clr(mon_clr), .high_cnt);

	// Clock at 20 MHz.
	always #25 core_clk = ~core_clk;

	// Tick strobes follow their enables, one pulse every cycle.
	always @(negedge core_clk) begin
		slow_clock_tick <= slow_en;
		fast_clock_tick <= fast_en;
	end

	// Counts interrupt pulses as they are sampled.
	always @(posedge core_clk) if (watchdog_timeout_irq === 1'b1) irq_cnt++;

	task automatic check(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	task automatic cfg(input logic [1:0] m, input logic s, input logic [7:0] w);
		@(negedge core_clk);
		cfg_output_mode = m;
		cfg_clock_source = s;
		cfg_watchdog_reload = w;
		cfg_wr = 1'b1;
		@(negedge core_clk);
		cfg_wr = 1'b0;
	endtask : cfg

	task automatic set_lim(input logic mx, input logic [7:0] v);
		@(negedge core_clk);
		if (mx) begin
			lim_max = v;
			lim_max_wr = 1'b1;
		end else begin
			lim_min = v;
			lim_min_wr = 1'b1;
		end
		@(negedge core_clk);
		lim_max_wr = 1'b0;
		lim_min_wr = 1'b0;
	endtask : set_lim

	// Counts lit cycles over a window of n cycles.
	task automatic measure(input int n, input logic [15:0] exp, input string nm);
		@(negedge core_clk);
		mon_clr = 1'b0;
		cyc(n);
		check(nm, high_cnt, exp);
		mon_clr = 1'b1;
	endtask : measure

	task automatic wd_tick;
		@(negedge core_clk);
		wdog_tick = 1'b1;
		@(negedge core_clk);
		wdog_tick = 1'b0;
	endtask : wd_tick

	task automatic wait_duty(input logic [7:0] v);
		for (int i = 0; i < 3000 && duty_status !== v; i++)
			cyc(1);
		check("duty", duty_status, v);
	endtask : wait_duty

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (40000) @(posedge core_clk);
		error_cnt++;
		end_sim();
	end

	// Main sequence of tests.
	initial begin
		cyc(12);
		rst_n = 1'b1;
		cyc(1);
		check("wdog rst", watchdog_count, 8'h14);
		// Blink on slow ticks with 7-bit resolution set, which must be ignored.
		cfg_counter_resolution = LBBP_RES_7BIT;
		prescale_reload = 12'h001;
		slow_en = 1'b1;
		set_lim(1'b0, 8'h40);
		cfg(LBBP_MODE_BLINK, LBBP_SRC_SLOW, 8'h00);
		cyc(600);
		measure(512, 16'd128, "blink");
		set_lim(1'b0, 8'h00);
		cyc(3);
		measure(512, 16'd0, "duty0");
		set_lim(1'b0, 8'hFF);
		cyc(3);
		measure(512, 16'd512, "dutyff");
		// Fast source without prescaling; slow ticks stop.
		slow_en = 1'b0;
		fast_en = 1'b1;
		prescale_reload = 12'h000;
		cfg(LBBP_MODE_BLINK, LBBP_SRC_FAST, 8'h00);
		set_lim(1'b0, 8'h80);
		cyc(300);
		measure(256, 16'd128, "fast");
		cfg(LBBP_MODE_OFF, LBBP_SRC_FAST, 8'h00);
		cyc(2);
		measure(100, 16'd0, "off");
		check("off duty", duty_status, 8'h00);
		cfg(LBBP_MODE_ON, LBBP_SRC_FAST, 8'h00);
		cyc(2);
		measure(100, 16'd100, "on");
		// Watchdog: count down, pause, expire, reload through the duty byte.
		cfg(LBBP_MODE_BLINK, LBBP_SRC_FAST, 8'h03);
		check("wd load", watchdog_count, 8'h03);
		wd_tick();
		wd_tick();
		check("wd dec", watchdog_count, 8'h01);
		cyc(20);
		check("wd hold", watchdog_count, 8'h01);
		irq_cnt = 0;
		wd_tick();
		cyc(5);
		check("irq", irq_cnt[15:0], 16'd1);
		check("wd mode", output_mode, LBBP_MODE_ON);
		check("wd pin", pwm_out, 1'b1);
		// A duty write reloads from the stored field, not the live input.
		cfg_watchdog_reload = 8'h07;
		set_lim(1'b0, 8'h10);
		check("wd min", watchdog_count, 8'h03);
		cfg(LBBP_MODE_BLINK, LBBP_SRC_FAST, 8'h00);
		wd_tick();
		wd_tick();
		check("wd off", watchdog_count, 8'h00);
		check("no irq", irq_cnt[15:0], 16'd1);
		// Breathing in 6-bit resolution between 00h and 20h.
		fast_en = 1'b0;
		slow_en = 1'b1;
		cfg_counter_resolution = LBBP_RES_6BIT;
		set_lim(1'b0, 8'h00);
		set_lim(1'b1, 8'h20);
		cfg(LBBP_MODE_BREATHE, LBBP_SRC_FAST, 8'h00);
		wait_duty(8'h20);
		cyc(2);
		measure(64, 16'd32, "breathe");
		wait_duty(8'h00);
		wait_duty(8'h20);
		// Asymmetric ramps: rising uses field 0, falling uses field 4.
		cfg(LBBP_MODE_OFF, LBBP_SRC_FAST, 8'h00);
		cfg_symmetric = 1'b0;
		segment_step_sizes = 32'h00030008;
		cfg(LBBP_MODE_BREATHE, LBBP_SRC_FAST, 8'h00);
		wait_duty(8'h18);
		wait_duty(8'h20);
		wait_duty(8'h1D);
		cfg_soft_reset = 1'b1;
		cfg(LBBP_MODE_BREATHE, LBBP_SRC_FAST, 8'h00);
		cyc(3);
		check("srst", duty_status, 8'h00);
		end_sim();
	end
endmodule : test_led_blink_breathe_pwm
